// ===== hw/fpr_pkg.sv
// package: constants and types for the fp register file and store lane block
package fpr_pkg;
  localparam int FPR_COUNT      = 32;
  localparam int FPR_IDX_W      = 5;
  localparam int FPR_DATA_W     = 64;
  localparam int HALF_W         = 32;
  localparam int ELEM_BYTES     = 8;
  localparam int ELEM_BYTES_W4  = 4;
  localparam int LANE_ADDR_W    = 3;
  localparam int LEN_W          = 3;
  localparam int CSR_W          = 32;
  localparam int CC_W           = 3;
  localparam int CC0_BIT        = 23;
  localparam int CC_BASE_BIT    = 24;
  localparam logic [CSR_W-1:0]      CSR_RESET = 32'h0000_0000;
  localparam logic [FPR_DATA_W-1:0] FPR_RESET = 64'h0000_0000_0000_0000;
  localparam logic [HALF_W-1:0]     UNDEF_HALF = 32'h0000_0000;
  localparam logic [FPR_DATA_W-1:0] UNDEF_VAL  = 64'h0000_0000_0000_0000;

  // access length code: byte count minus one
  localparam logic [LEN_W-1:0] LEN_BYTE       = 3'h0;
  localparam logic [LEN_W-1:0] LEN_HALF       = 3'h1;
  localparam logic [LEN_W-1:0] THREE_BYTE_LEN = 3'h2;
  localparam logic [LEN_W-1:0] LEN_WORD       = 3'h3;
  localparam logic [LEN_W-1:0] FIVE_BYTE_LEN  = 3'h4;
  localparam logic [LEN_W-1:0] SIX_BYTE_LEN   = 3'h5;
  localparam logic [LEN_W-1:0] SEVEN_BYTE_LEN = 3'h6;
  localparam logic [LEN_W-1:0] LEN_DOUBLE     = 3'h7;

  typedef enum logic [2:0] {
    FMT_SINGLE, FMT_DOUBLE, FMT_WORD, FMT_LONG, PAIRED_SINGLE_FMT,
    FMT_UNINT_WORD, FMT_UNINT_DOUBLE, FMT_OTHER
  } fpr_fmt_t;

  typedef enum logic [1:0] {
    ROUTE_UNCACHED, ROUTE_CACHED, ROUTE_COHERENT
  } fpr_route_t;

  typedef struct packed {
    logic [FPR_COUNT-1:0][FPR_DATA_W-1:0] regs;
    logic [CSR_W-1:0]                     float_ctrl_status;
    logic [FPR_DATA_W-1:0]                rd_data;
    logic                                 rd_valid;
    logic                                 rd_undef;
    logic                                 wr_undef;
    logic                                 cc_val;
    logic                                 st_valid;
    logic [ELEM_BYTES-1:0]                st_be;
    logic [FPR_DATA_W-1:0]                st_data;
    logic [FPR_DATA_W-4:0]                st_addr;
    fpr_route_t                           st_route;
    logic                                 sync_done;
  } fpr_state_t;
endpackage

// ===== hw/fpr_lane_if.sv
// interface: lane mask request and answer between top and lane decoder
`timescale 1ns/1ps
interface fpr_lane_if;
  import fpr_pkg::*;
  logic                   wide_elem;
  logic [LANE_ADDR_W-1:0] low_addr;
  logic [LEN_W-1:0]       access_len;
  logic [ELEM_BYTES-1:0]  byte_en;
  modport requester (output wide_elem, output low_addr, output access_len, input byte_en);
  modport decoder   (input wide_elem, input low_addr, input access_len, output byte_en);
endinterface

// ===== hw/fpr_lane_dec.sv
// module: byte lane enables from low address bits and access length
`timescale 1ns/1ps
module fpr_lane_dec (
  fpr_lane_if.decoder lane
);
  import fpr_pkg::*;
  logic [LANE_ADDR_W-1:0] start;
  logic [3:0]             count;
  logic [3:0]             limit;

  // ------------------------------------------------------------
  // lane mask
  // ------------------------------------------------------------
  always_comb begin
    start = lane.wide_elem ? lane.low_addr : {1'b0, lane.low_addr[1:0]};
    count = {1'b0, lane.access_len} + 4'h1;
    limit = lane.wide_elem ? 4'(ELEM_BYTES) : 4'(ELEM_BYTES_W4);
  end

  genvar b;
  generate
    for (b = 0; b < ELEM_BYTES; b++) begin : g_lane
      // lanes past the element end are dropped, never wrapped
      assign lane.byte_en[b] = (4'(b) >= {1'b0, start})
                            && (4'(b) < ({1'b0, start} + count))
                            && (4'(b) < limit);
    end
  endgenerate
endmodule

// ===== hw/fpr_core.sv
// module: fp register file, condition codes and store lane staging
`timescale 1ns/1ps
// Behaviour
// - store changes only selected bytes
// - length code is byte count minus one
// - element is register wide, aligned
// - store routed by cacheability attribute
// - prefetch changes no visible state
// - sync orders selected accesses for all
// - narrow double read pairs n+1 and n
// - narrow double write splits into pair
// - odd register pair access is undefined
// - long and paired need wide mode
// - cc0 is bit 23, else 24 plus n
// - setting cc replaces only that bit
module fpr_core (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  input  wire logic                          i_narrow_reg_mode,
  input  wire logic                          i_wide_elem,
  input  wire logic                          i_rd_en,
  input  wire logic [fpr_pkg::FPR_IDX_W-1:0] i_rd_idx,
  input  wire fpr_pkg::fpr_fmt_t             i_rd_fmt,
  input  wire logic                          i_wr_en,
  input  wire logic [fpr_pkg::FPR_IDX_W-1:0] i_wr_idx,
  input  wire fpr_pkg::fpr_fmt_t             i_wr_fmt,
  input  wire logic [fpr_pkg::FPR_DATA_W-1:0] i_wr_data,
  input  wire logic                          i_cc_set,
  input  wire logic [fpr_pkg::CC_W-1:0]      i_cond_code_num,
  input  wire logic                          i_cc_val,
  input  wire logic                          i_st_en,
  input  wire logic [fpr_pkg::FPR_DATA_W-1:0] i_st_addr,
  input  wire logic [fpr_pkg::LEN_W-1:0]     i_access_len,
  input  wire logic [fpr_pkg::FPR_DATA_W-1:0] i_mem_element,
  input  wire logic [1:0]                    i_cache_coherency_attr,
  input  wire logic                          i_prefetch,
  input  wire logic                          i_sync,
  output logic [fpr_pkg::FPR_DATA_W-1:0]     o_rd_data,
  output logic                               o_rd_valid,
  output logic                               o_rd_undef,
  output logic                               o_wr_undef,
  output logic                               o_cc_val,
  output logic [fpr_pkg::CSR_W-1:0]          o_float_ctrl_status,
  output logic                               o_st_valid,
  output logic [fpr_pkg::ELEM_BYTES-1:0]     o_st_be,
  output logic [fpr_pkg::FPR_DATA_W-1:0]     o_st_data,
  output logic [fpr_pkg::FPR_DATA_W-4:0]     o_st_addr,
  output fpr_pkg::fpr_route_t                o_st_route,
  output logic                               o_sync_done
);
  import fpr_pkg::*;

  fpr_state_t s_q;
  fpr_state_t s_d;
  fpr_lane_if lane ();

  // ------------------------------------------------------------
  // lane decoder
  // ------------------------------------------------------------
  assign lane.wide_elem  = i_wide_elem;
  assign lane.low_addr   = i_st_addr[LANE_ADDR_W-1:0];
  assign lane.access_len = i_access_len;

  fpr_lane_dec u_lane (
    .lane (lane)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [FPR_IDX_W-1:0] rd_hi;
    logic [FPR_IDX_W-1:0] wr_hi;
    logic [FPR_DATA_W-1:0] mask;
    s_d   = s_q;
    rd_hi = i_rd_idx | 5'h01;
    wr_hi = i_wr_idx | 5'h01;
    mask  = '0;
    s_d.rd_valid  = 1'b0;
    s_d.wr_undef  = 1'b0;
    s_d.st_valid  = 1'b0;
    s_d.sync_done = 1'b0;

    // read port: callers read in the format last written
    if (i_rd_en) begin
      s_d.rd_valid = 1'b1;
      s_d.rd_undef = 1'b0;
      s_d.rd_data  = s_q.regs[i_rd_idx];
      case (i_rd_fmt)
        FMT_SINGLE, FMT_WORD, FMT_UNINT_WORD: begin
          s_d.rd_data = s_q.regs[i_rd_idx];
        end
        FMT_DOUBLE, FMT_UNINT_DOUBLE: begin
          if (i_narrow_reg_mode) begin
            if (i_rd_idx[0]) begin
              s_d.rd_data  = UNDEF_VAL;
              s_d.rd_undef = 1'b1;
            end else begin
              s_d.rd_data = {s_q.regs[rd_hi][HALF_W-1:0],
                             s_q.regs[i_rd_idx][HALF_W-1:0]};
            end
          end
        end
        FMT_LONG, PAIRED_SINGLE_FMT: begin
          if (i_narrow_reg_mode) begin
            s_d.rd_data  = UNDEF_VAL;
            s_d.rd_undef = 1'b1;
          end
        end
        default: begin
          s_d.rd_data  = UNDEF_VAL;
          s_d.rd_undef = 1'b1;
        end
      endcase
    end

    // write port: undefined cases leave the file untouched
    if (i_wr_en) begin
      case (i_wr_fmt)
        FMT_SINGLE, FMT_WORD, FMT_UNINT_WORD: begin
          s_d.regs[i_wr_idx] = i_wr_data;
        end
        FMT_DOUBLE, FMT_UNINT_DOUBLE: begin
          if (i_narrow_reg_mode) begin
            if (i_wr_idx[0]) begin
              s_d.wr_undef = 1'b1;
            end else begin
              s_d.regs[i_wr_idx] = {UNDEF_HALF, i_wr_data[HALF_W-1:0]};
              s_d.regs[wr_hi]    = {UNDEF_HALF, i_wr_data[FPR_DATA_W-1:HALF_W]};
            end
          end else begin
            s_d.regs[i_wr_idx] = i_wr_data;
          end
        end
        FMT_LONG, PAIRED_SINGLE_FMT: begin
          if (i_narrow_reg_mode) begin
            s_d.wr_undef = 1'b1;
          end else begin
            s_d.regs[i_wr_idx] = i_wr_data;
          end
        end
        default: begin
          s_d.wr_undef = 1'b1;
        end
      endcase
    end

    // condition codes
    if (i_cond_code_num == 3'h0) begin
      s_d.cc_val = s_q.float_ctrl_status[CC0_BIT];
    end else begin
      s_d.cc_val = s_q.float_ctrl_status[CC_BASE_BIT + int'(i_cond_code_num)];
    end
    if (i_cc_set) begin
      if (i_cond_code_num == 3'h0) begin
        s_d.float_ctrl_status[CC0_BIT] = i_cc_val;
      end else begin
        s_d.float_ctrl_status[CC_BASE_BIT + int'(i_cond_code_num)] = i_cc_val;
      end
    end

    // store staging: data is masked to the selected lanes, lane mask marks valid bytes
    if (i_st_en) begin
      for (int b = 0; b < ELEM_BYTES; b++) begin
        mask[b*8 +: 8] = {8{lane.byte_en[b]}};
      end
      s_d.st_valid = 1'b1;
      s_d.st_be    = lane.byte_en;
      s_d.st_data  = i_mem_element & mask;
      s_d.st_addr  = i_st_addr[FPR_DATA_W-1:LANE_ADDR_W];
      case (i_cache_coherency_attr)
        2'h0:    s_d.st_route = ROUTE_UNCACHED;
        2'h1:    s_d.st_route = ROUTE_CACHED;
        default: s_d.st_route = ROUTE_COHERENT;
      endcase
    end

    // prefetch is only a hint: no visible state is touched
    if (i_prefetch) begin
      s_d.st_valid = s_d.st_valid;
    end

    // with a single in-order staging register, every earlier store has
    // already been presented, so a barrier with no store in the same cycle completes the next cycle
    if (i_sync) begin
      s_d.sync_done = ~i_st_en;
    end

    if (i_reset) begin
      s_d                   = '0;
      s_d.regs              = {FPR_COUNT{FPR_RESET}};
      s_d.float_ctrl_status = CSR_RESET;
      s_d.st_route          = ROUTE_UNCACHED;
    end
  end

  always_ff @(posedge i_clk) begin
    s_q <= s_d;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_rd_data           = s_q.rd_data;
  assign o_rd_valid          = s_q.rd_valid;
  assign o_rd_undef          = s_q.rd_undef;
  assign o_wr_undef          = s_q.wr_undef;
  assign o_cc_val            = s_q.cc_val;
  assign o_float_ctrl_status = s_q.float_ctrl_status;
  assign o_st_valid          = s_q.st_valid;
  assign o_st_be             = s_q.st_be;
  assign o_st_data           = s_q.st_data;
  assign o_st_addr           = s_q.st_addr;
  assign o_st_route          = s_q.st_route;
  assign o_sync_done         = s_q.sync_done;
endmodule

// ===== bench/fpr_core_monitor.sv
// checker: port assertions for the fp register file and store lanes
`timescale 1ns/1ps
module fpr_core_monitor
  import fpr_pkg::*;
(
  input wire logic                i_clk,
  input wire logic                i_reset,
  input wire logic                i_wide_elem,
  input wire logic                i_st_en,
  input wire logic [63:0]         i_st_addr,
  input wire logic [2:0]          i_access_len,
  input wire logic [63:0]         i_mem_element,
  input wire logic [1:0]          i_cache_coherency_attr,
  input wire logic                i_prefetch,
  input wire logic                i_sync,
  input wire logic                i_cc_set,
  input wire logic [2:0]          i_cond_code_num,
  input wire logic                i_cc_val,
  input wire logic                o_cc_val,
  input wire logic [31:0]         o_float_ctrl_status,
  input wire logic                o_st_valid,
  input wire logic [7:0]          o_st_be,
  input wire logic [63:0]         o_st_data,
  input wire fpr_pkg::fpr_route_t o_st_route,
  input wire logic                o_sync_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [63:0] be_mask;
  logic [31:0] cc_mask;
  fpr_route_t  exp_route;
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      be_mask[b*8 +: 8] = {8{o_st_be[b]}};
    end
  end
  assign cc_mask = (i_cond_code_num == 3'h0) ? 32'h0080_0000 : 32'h0100_0000 << i_cond_code_num;
  assign exp_route = (i_cache_coherency_attr == 2'h0) ? ROUTE_UNCACHED :
                     (i_cache_coherency_attr == 2'h1) ? ROUTE_CACHED : ROUTE_COHERENT;
  lane_count_a: assert property (i_st_en && i_wide_elem && 4'(i_st_addr[2:0]) + 4'(i_access_len) < 4'h8 |=>
    o_st_be[$past(i_st_addr[2:0])] && $countones(o_st_be) == $past(i_access_len) + 1) else $error("bad lanes");
  store_data_a: assert property (i_st_en |=> o_st_data == ($past(i_mem_element) & be_mask))
    else $error("bad store data");
  route_pick_a: assert property (i_st_en |=> o_st_valid && o_st_route == $past(exp_route))
    else $error("bad store route");
  prefetch_quiet_a: assert property (i_prefetch && !i_st_en && !i_cc_set |=>
    !o_st_valid && $stable(o_float_ctrl_status)) else $error("hint changed state");
  sync_done_a: assert property (i_sync && !i_st_en |=> o_sync_done) else $error("no sync done");
  sync_cause_a: assert property (o_sync_done |-> $past(i_sync)) else $error("stray sync done");
  cc_read_a: assert property (!$past(i_reset) |->
    o_cc_val == |($past(o_float_ctrl_status) & $past(cc_mask))) else $error("bad cc value");
  cc_write_a: assert property (i_cc_set |=> o_float_ctrl_status ==
    (($past(o_float_ctrl_status) & ~$past(cc_mask)) | ($past(i_cc_val) ? $past(cc_mask) : 32'h0)))
    else $error("bad cc write");
  cover property (i_st_en && i_access_len == 3'h7);
  cover property (i_cc_set && i_cond_code_num == 3'h7);
  cover property (i_sync);
endmodule
bind fpr_core fpr_core_monitor fpr_core_monitor_i (.*);

// ===== bench/fpr_mem_model.sv
// partner: byte-lane memory that applies staged stores
`timescale 1ns/1ps
module fpr_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_st_valid,
  input  wire logic [7:0]  i_st_be,
  input  wire logic [63:0] i_st_data,
  input  wire logic [60:0] i_st_addr,
  input  wire logic [3:0]  i_peek_idx,
  output logic      [63:0] o_peek_data
);
  logic [63:0] mem_q [16];
  initial for (int e = 0; e < 16; e++) mem_q[e] = {8{8'hA5}};
  assign o_peek_data = mem_q[i_peek_idx];
  // unselected lanes keep old contents, whatever the data bus carries there
  always @(posedge i_clk) begin
    for (int b = 0; b < 8; b++) begin
      if (i_st_valid && i_st_be[b]) mem_q[i_st_addr[3:0]][b*8 +: 8] <= i_st_data[b*8 +: 8];
    end
  end
endmodule

// ===== bench/fp_register_format_and_store_lanes_tb.sv
// testbench: stores, register pairing and condition codes against a bench model
`timescale 1ns/1ps
module fp_register_format_and_store_lanes_tb;
  import fpr_pkg::*;
  logic        i_clk, i_reset, i_narrow_reg_mode, i_wide_elem, i_rd_en, i_wr_en, i_cc_set, i_cc_val;
  logic        i_st_en, i_prefetch, i_sync, o_rd_valid, o_rd_undef, o_wr_undef, o_cc_val;
  logic        o_st_valid, o_sync_done;
  logic [4:0]  i_rd_idx, i_wr_idx;
  logic [2:0]  i_cond_code_num, i_access_len;
  logic [1:0]  i_cache_coherency_attr;
  logic [3:0]  peek_idx;
  logic [7:0]  o_st_be;
  logic [31:0] o_float_ctrl_status, exp_csr;
  logic [60:0] o_st_addr;
  logic [63:0] i_wr_data, i_st_addr, i_mem_element, o_rd_data, o_st_data, peek_data, d1, d2;
  logic [63:0] exp_mem [16];
  fpr_fmt_t    i_rd_fmt, i_wr_fmt, ef;
  fpr_route_t  o_st_route;
  int          mismatches, checks, cyc;
  fpr_core fpr_core_i (.*);
  fpr_mem_model fpr_mem_model_i (.i_clk(i_clk), .i_st_valid(o_st_valid), .i_st_be(o_st_be),
    .i_st_data(o_st_data), .i_st_addr(o_st_addr), .i_peek_idx(peek_idx), .o_peek_data(peek_data));
  initial begin
    i_clk = 1'h0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // generous ceiling: the whole sequence needs about 140 cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic store(logic w, logic [63:0] a, logic [2:0] len, logic [63:0] d, logic [1:0] at);
    int st;
    logic [7:0] be;
    @(posedge i_clk);
    i_wide_elem <= w;
    i_st_addr <= a;
    i_access_len <= len;
    i_mem_element <= d;
    i_cache_coherency_attr <= at;
    i_st_en <= 1'h1;
    @(posedge i_clk);
    i_st_en <= 1'h0;
    st = w ? a[2:0] : a[1:0];
    be = 8'h00;
    for (int k = 0; k <= len; k++) if (st + k < (w ? 8 : 4)) be[st + k] = 1'h1;
    for (int b = 0; b < 8; b++) if (be[b]) exp_mem[a[6:3]][b*8 +: 8] = d[b*8 +: 8];
    #1 check("lanes", o_st_be, be);
    check("route", o_st_route, at == 0 ? ROUTE_UNCACHED : at == 1 ? ROUTE_CACHED : ROUTE_COHERENT);
  endtask
  task automatic acc(logic w, logic [4:0] n, fpr_fmt_t f, logic [63:0] d, logic u);
    @(posedge i_clk);
    i_wr_en <= w;
    i_rd_en <= !w;
    i_wr_idx <= n;
    i_rd_idx <= n;
    i_wr_fmt <= f;
    i_rd_fmt <= f;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr_en <= 1'h0;
    i_rd_en <= 1'h0;
    #1 check("undefined flag", w ? o_wr_undef : o_rd_undef, u);
    if (!w) check("read data", o_rd_data, u ? 64'h0 : d);
    if (!w) check("read valid", o_rd_valid, 1'h1);
  endtask
  task automatic cc(logic [2:0] n, logic v);
    @(posedge i_clk);
    i_cc_set <= 1'h1;
    i_cond_code_num <= n;
    i_cc_val <= v;
    @(posedge i_clk);
    i_cc_set <= 1'h0;
    exp_csr[(n == 0) ? 23 : 24 + n] = v;
    #1 check("csr", o_float_ctrl_status, exp_csr);
    @(posedge i_clk);
    #1 check("cc value", o_cc_val, v);
  endtask
  initial begin
    {i_narrow_reg_mode, i_wide_elem, i_rd_en, i_wr_en, i_cc_set, i_cc_val, i_st_en} = 7'h00;
    {i_prefetch, i_sync, i_rd_idx, i_wr_idx, i_cond_code_num, i_access_len} = 18'h0;
    {i_cache_coherency_attr, i_wr_data, i_st_addr, i_mem_element} = 194'h0;
    i_rd_fmt = FMT_SINGLE;
    i_wr_fmt = FMT_SINGLE;
    i_reset = 1'h1;
    peek_idx = 4'h0;
    exp_csr = 32'h0;
    for (int e = 0; e < 16; e++) exp_mem[e] = {8{8'hA5}};
    void'($urandom(2769));
    repeat (12) @(posedge i_clk);
    i_reset <= 1'h0;
    for (int i = 0; i < 24; i++) store(i % 3 != 0, {$urandom, $urandom}, 3'(i % 8), {$urandom, $urandom}, 2'(i % 4));
    @(posedge i_clk);
    for (int e = 0; e < 16; e++) begin
      peek_idx = 4'(e);
      #1 check("memory", peek_data, exp_mem[e]);
    end
    $display("store test done");
    d1 = {$urandom, $urandom};
    d2 = {$urandom, $urandom};
    acc(1'h1, 5'h04, FMT_LONG, d1, 1'h0);
    acc(1'h0, 5'h04, FMT_LONG, d1, 1'h0);
    acc(1'h1, 5'h05, FMT_DOUBLE, d2, 1'h0);
    acc(1'h0, 5'h05, FMT_DOUBLE, d2, 1'h0);
    @(posedge i_clk);
    i_narrow_reg_mode <= 1'h1;
    acc(1'h1, 5'h08, FMT_DOUBLE, d1, 1'h0);
    for (int f = 0; f < 8; f++) begin
      ef = fpr_fmt_t'(f);
      // each read uses the format the register was last written in
      if (ef inside {FMT_LONG, PAIRED_SINGLE_FMT, FMT_OTHER}) begin
        acc(1'h1, 5'h08, ef, d1, 1'h1);
        acc(1'h0, 5'h08, ef, 64'h0, 1'h1);
      end else begin
        acc(1'h1, 5'h08, ef, d1, 1'h0);
        if (ef inside {FMT_DOUBLE, FMT_UNINT_DOUBLE}) acc(1'h0, 5'h08, ef, d1, 1'h0);
        else acc(1'h0, 5'h08, ef, d1, 1'h0);
      end
    end
    acc(1'h1, 5'h09, FMT_DOUBLE, d2, 1'h1);
    // uninterpreted read of the pair's upper register keeps the format rule
    acc(1'h0, 5'h09, FMT_UNINT_WORD, {32'h0, d1[63:32]}, 1'h0);
    acc(1'h1, 5'h06, PAIRED_SINGLE_FMT, d2, 1'h1);
    acc(1'h0, 5'h06, FMT_SINGLE, 64'h0, 1'h0);
    $display("register test done");
    for (int n = 0; n < 8; n++) cc(3'(n), 1'($urandom));
    $display("condition code test done");
    @(posedge i_clk);
    i_prefetch <= 1'h1;
    @(posedge i_clk);
    i_prefetch <= 1'h0;
    i_sync <= 1'h1;
    @(posedge i_clk);
    i_sync <= 1'h0;
    #1 check("sync done", o_sync_done, 1'h1);
    check("csr after hint", o_float_ctrl_status, exp_csr);
    check("no store on hint", o_st_valid, 1'h0);
    @(posedge i_clk);
    i_sync <= 1'h1;
    i_st_en <= 1'h1;
    @(posedge i_clk);
    i_sync <= 1'h0;
    i_st_en <= 1'h0;
    #1 check("sync with store", o_sync_done, 1'h0);
    check("store beside sync", o_st_valid, 1'h1);
    $display("ordering test done");
    tally_and_finish();
  end
endmodule
